// ### design/touch_host_control_irq.sv
`timescale 1ns/1ps
// How it works
// - At start-up use valid non-volatile store, else fixed defaults.
// - Copy chosen source into shadow memory; run only from shadow memory.
// - Shadow memory cleared by reset, reloaded automatically afterwards.
// - Sixteen host registers over I2C: status, information, mode control.
// - Host may overwrite shadow parameters any time; lost at reset.
// - Host writes shadow, then signals; device copies shadow into store.
// - I2C slave at 100/400 kb/s, address 0x2B unless store or a host shadow write changes it.
// - Reset from power-up, hardware reset pin, or software reset.
// - Interrupt held low during power-up, released when operational.
// - Stay in reset while pin low; power-up sequence when it rises.
// - Software reset on 0xDE then 0x00 written to 0xB1.
// - In Active and Doze the interrupt updates once per scan period.
// - Interrupt on enabled touch, release, and input pin edges.
// - Interrupt on mode entry, compensation, shadow write, store burn.
// - Interrupt kept asserted during any reset.
// - Interrupt cleared by reading the source register or reset end.
// - Eight pins, each input, host PWM output, or general output.
// - Output modes apply per-pin polarity from shadow memory.
// - PWM is an 8-bit counter clocked at about 2 MHz.
// - Input pins have optional pull-up/down and optional debounce.
// - Input pin edge per pin raises interrupt and wakes Sleep/Doze.
module touch_host_control_irq (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  hw_reset_pin_n,
  // I2C pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_n,
  // Sensing core
  input  wire logic                  scan_tick,
  input  wire logic                  comp_done,
  input  wire logic [7:0]            button_touch,
  output touch_ctrl_pkg::opmode_t    opmode,
  // General-purpose pins
  input  wire logic [7:0]            gpio_i,
  output touch_ctrl_pkg::pins_t      gpio,
  // Interrupt
  output logic                       irq_out_n
);
  import touch_ctrl_pkg::*;

  state_t s_reg, s_next;
  logic [7:0] nonvolatile_param_store [16];
  logic       nvm_we;
  logic [3:0] nvm_idx;
  logic [7:0] nvm_wdata;
  logic       rd_src, latch, rst_ev, sw_rst;

  function automatic logic [7:0] rd_data(input core_t c);
    logic [7:0] d;
    d = 8'h00;
    unique case (c.ptr)
      REG_IRQ_SRC:  d = {1'b0, c.src};
      REG_BTN_STAT: d = c.btn;
      REG_PIN_STAT: d = c.gval;
      REG_OPM_STAT: d = {6'h00, c.mode};
      REG_MODE_REQ: d = {6'h00, c.mode_req};
      REG_SPM_ADDR: d = c.spm_ptr;
      REG_SPM_DATA: d = c.shadow_param_memory[c.spm_ptr[3:0]];
      REG_GPO_CTRL: d = c.pin_output_mode;
      default:      d = 8'h00;
    endcase
    return d;
  endfunction

  always_comb begin
    state_t n;
    core_t c;
    logic scl_r, scl_fl, sda_st, sda_sp, wr, pwm_t, nvm_ok;
    logic [7:0] wa, wd, ev_gpi;
    logic [6:0] ev;
    logic [1:0] pm;
    n = s_reg;
    scl_r = 1'b0;
    scl_fl = 1'b0;
    sda_st = 1'b0;
    sda_sp = 1'b0;
    pwm_t = 1'b0;
    nvm_ok = 1'b0;
    ev_gpi = 8'h00;
    pm = 2'h0;
    c = s_reg.co;
    wr = 1'b0;
    wa = 8'h00;
    wd = 8'h00;
    ev = '0;
    rd_src = 1'b0;
    sw_rst = 1'b0;
    nvm_we = 1'b0;
    nvm_idx = c.idx;
    nvm_wdata = c.shadow_param_memory[c.idx];
    // Pin synchronisers: value taken once stages two and three agree
    n.sy.scl = {s_reg.sy.scl[1:0], scl_i};
    n.sy.sda = {s_reg.sy.sda[1:0], sda_i};
    n.sy.rst = {s_reg.sy.rst[1:0], hw_reset_pin_n};
    if (s_reg.sy.scl[1] == s_reg.sy.scl[2]) n.sy.scl_f = s_reg.sy.scl[2];
    if (s_reg.sy.sda[1] == s_reg.sy.sda[2]) n.sy.sda_f = s_reg.sy.sda[2];
    if (s_reg.sy.rst[1] == s_reg.sy.rst[2]) n.sy.rst_f = s_reg.sy.rst[2];
    for (int i = 0; i < NUM_PINS; i++) begin
      n.sy.gin[i] = {s_reg.sy.gin[i][1:0], gpio_i[i]};
      if (s_reg.sy.gin[i][1] == s_reg.sy.gin[i][2]) n.sy.gin_f[i] = s_reg.sy.gin[i][2];
    end
    scl_r  = n.sy.scl_f & ~s_reg.sy.scl_f;
    scl_fl = ~n.sy.scl_f & s_reg.sy.scl_f;
    sda_st = s_reg.sy.scl_f & n.sy.scl_f & s_reg.sy.sda_f & ~n.sy.sda_f;
    sda_sp = s_reg.sy.scl_f & n.sy.scl_f & ~s_reg.sy.sda_f & n.sy.sda_f;
    // Configuration load and store burn
    unique case (c.phase)
      PH_LOAD: begin
        // Unwritten store never selects itself
        if (nonvolatile_param_store[SPM_SIG] == NVM_SIGNATURE) nvm_ok = 1'b1;
        if (c.idx == 4'h0) c.use_nvm = nvm_ok;
        if (c.use_nvm) c.shadow_param_memory[c.idx] = nonvolatile_param_store[c.idx];
        else c.shadow_param_memory[c.idx] = DEFAULT_SPM[c.idx];
        c.idx = c.idx + 4'h1;
        if (c.idx == 4'h0) c.phase = PH_RUN;
      end
      PH_BURN: begin
        nvm_we = 1'b1;
        if (c.idx == SPM_SIG) nvm_wdata = NVM_SIGNATURE;
        c.idx = c.idx + 4'h1;
        if (c.idx == 4'h0) begin
          c.phase = PH_RUN;
          ev[IRQ_NVM] = 1'b1;
        end
      end
      PH_HOLD: if (s_reg.sy.rst_f) c.phase = PH_LOAD;
      PH_RUN: ;
    endcase
    // I2C slave, ignores the bus until loaded
    if (sda_st && c.phase != PH_LOAD && c.phase != PH_HOLD) begin
      c.ist = I_ADDR;
      c.cnt = 4'h0;
      c.first = 1'b1;
      c.drv = 1'b0;
    end else if (sda_sp) begin
      c.ist = I_IDLE;
      c.drv = 1'b0;
    end else if (scl_r) begin
      if (c.ist == I_ADDR || c.ist == I_WR) c.sh = {c.sh[6:0], s_reg.sy.sda_f};
      if (c.ist == I_ADDR || c.ist == I_WR || c.ist == I_RD) c.cnt = c.cnt + 4'h1;
      if (c.ist == I_RACK && s_reg.sy.sda_f) c.ist = I_IDLE;
    end else if (scl_fl) begin
      unique case (c.ist)
        I_ADDR: if (c.cnt == 4'h8) begin
          if (c.sh[7:1] == c.shadow_param_memory[SPM_ADDR][6:0]) begin
            c.drv = 1'b1;
            c.rw = c.sh[0];
            c.ist = I_AACK;
          end else c.ist = I_IDLE;
        end
        I_WR: if (c.cnt == 4'h8) begin
          c.drv = 1'b1;
          c.ist = I_WACK;
          if (c.first) c.ptr = c.sh;
          else begin
            wr = 1'b1;
            wa = c.ptr;
            wd = c.sh;
            c.ptr = c.ptr + 8'h01;
          end
          c.first = 1'b0;
        end
        I_WACK: begin
          // Key byte is acknowledged before the reset takes hold
          sw_rst = c.key_armed && c.sh == SW_RESET_KEY2
                   && c.ptr == REG_SW_RESET + 8'h01;
          c.drv = 1'b0;
          c.cnt = 4'h0;
          c.ist = I_WR;
        end
        I_RD: begin
          if (c.cnt == 4'h8) begin
            c.drv = 1'b0;
            c.ist = I_RACK;
          end else begin
            c.sh = {c.sh[6:0], 1'b0};
            c.drv = ~c.sh[7];
          end
        end
        I_AACK, I_RACK: begin
          if (c.ist == I_AACK && !c.rw) begin
            c.drv = 1'b0;
            c.ist = I_WR;
          end else begin
            c.sh = rd_data(c);
            rd_src = (c.ptr == REG_IRQ_SRC);
            c.ptr = c.ptr + 8'h01;
            c.drv = ~c.sh[7];
            c.ist = I_RD;
          end
          c.cnt = 4'h0;
        end
        I_IDLE: ;
      endcase
    end
    // Register writes
    if (wr) begin
      if (wa == REG_SW_RESET) begin
        c.key_armed = (wd == SW_RESET_KEY1) || (c.key_armed && wd == SW_RESET_KEY2);
      end
      unique case (wa)
        REG_MODE_REQ: if (wd[1:0] != 2'h3) begin
          c.mode_req = opmode_t'(wd[1:0]);
          c.mode_pend = 1'b1;
        end
        REG_SPM_ADDR: c.spm_ptr = wd;
        REG_SPM_DATA: begin
          c.shadow_param_memory[c.spm_ptr[3:0]] = wd;
          ev[IRQ_SPM] = 1'b1;
        end
        REG_NVM_CTRL: if (wd == NVM_BURN_KEY && c.phase == PH_RUN) begin
          c.phase = PH_BURN;
          c.idx = 4'h0;
        end
        REG_GPO_CTRL: c.pin_output_mode = wd;
        default: ;
      endcase
    end
    // Button and input pin events
    ev[IRQ_COMP] = comp_done;
    ev[IRQ_TOUCH] = |(button_touch & ~c.btn) & c.shadow_param_memory[SPM_BTN_IRQ][0];
    ev[IRQ_RELEASE] = |(~button_touch & c.btn) & c.shadow_param_memory[SPM_BTN_IRQ][1];
    c.btn = button_touch;
    pwm_t = (c.pre == PWM_DIV - 6'h01);
    c.pre = pwm_t ? 6'h00 : c.pre + 6'h01;
    if (pwm_t) c.pwm = c.pwm + 8'h01;
    ev_gpi = 8'h00;
    for (int i = 0; i < NUM_PINS; i++) begin
      pm = i < 4 ? c.shadow_param_memory[SPM_MODE_LO][2*i +: 2] : c.shadow_param_memory[SPM_MODE_HI][2*(i-4) +: 2];
      if (pwm_t) c.gdb[i] = s_reg.sy.gin_f[i];
      if (pm == PIN_INPUT && (!c.shadow_param_memory[SPM_DEB][i] || (pwm_t && c.gdb[i] == s_reg.sy.gin_f[i])))
        c.gval[i] = s_reg.sy.gin_f[i];
      ev_gpi[i] = (c.gval[i] & ~s_reg.co.gval[i] & c.shadow_param_memory[SPM_RISE][i]) |
                  (~c.gval[i] & s_reg.co.gval[i] & c.shadow_param_memory[SPM_FALL][i]);
      c.pins.oe_n[i] = (pm == PIN_INPUT) || pm == 2'h3;
      c.pins.out[i] = c.shadow_param_memory[SPM_POL][i] ^ (pm == PIN_HOST_PWM ? c.pwm < c.shadow_param_memory[SPM_INTENS]
                      : c.pin_output_mode[i]);
      c.pins.pull_up[i] = pm == PIN_INPUT && c.shadow_param_memory[SPM_PULL_EN][i] && c.shadow_param_memory[SPM_PULL_UP][i];
      c.pins.pull_dn[i] = pm == PIN_INPUT && c.shadow_param_memory[SPM_PULL_EN][i] && !c.shadow_param_memory[SPM_PULL_UP][i];
    end
    ev[IRQ_GPI] = |ev_gpi;
    if (|ev_gpi && c.mode != OPM_ACTIVE) begin
      c.mode_req = OPM_ACTIVE;
      c.mode_pend = 1'b1;
    end
    // Sources reach the line once per scan; Sleep has no scans
    latch = scan_tick || c.mode == OPM_SLEEP;
    if (latch && c.mode_pend) begin
      c.mode = c.mode_req;
      c.mode_pend = 1'b0;
      ev[IRQ_OPMODE] = 1'b1;
    end
    c.src = (rd_src ? 7'h00 : c.src) | (latch ? c.pend : 7'h00);
    c.pend = (latch ? 7'h00 : c.pend) | ev;
    if (c.phase != PH_RUN && c.phase != PH_BURN) begin
      c.src = 7'h00;
      c.pend = 7'h00;
    end
    n.co = c;
    rst_ev = !s_reg.sy.rst_f || sw_rst;
    if (rst_ev) begin
      n.co = CORE_RESET;
      if (!s_reg.sy.rst_f) n.co.phase = PH_HOLD;
    end
    s_next = n;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) s_reg <= '{sy: SYNC_RESET, co: CORE_RESET};
    else s_reg <= s_next;
  end

  always_ff @(posedge ref_clk) begin
    if (nvm_we) nonvolatile_param_store[nvm_idx] <= nvm_wdata;
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~s_reg.co.drv;
  assign opmode = s_reg.co.mode;
  assign gpio = s_reg.co.pins;
  // Low while loading or held in reset, else while any latched source bit in src is set
  assign irq_out_n = !((s_reg.co.phase == PH_LOAD) || (s_reg.co.phase == PH_HOLD)
                       || (|s_reg.co.src));

  AST_RESET_IRQ: assert property (@(posedge ref_clk) disable iff (!resetn)
    (s_reg.co.phase == PH_LOAD || s_reg.co.phase == PH_HOLD) |-> !irq_out_n)
    else $error("irq line high during reset");
  AST_LOAD_END: assert property (@(posedge ref_clk) disable iff (!resetn)
    (s_reg.co.phase == PH_LOAD && s_reg.co.idx == SPM_LAST && !rst_ev)
    |=> s_reg.co.phase == PH_RUN && irq_out_n)
    else $error("load did not finish after 16 words");
  AST_READ_CLEAR: assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_src && !latch && !rst_ev) |=> s_reg.co.src == 7'h00)
    else $error("source read did not clear");
  AST_SCAN_ONLY: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!latch && !rd_src && !rst_ev && s_reg.co.phase == PH_RUN)
    |=> s_reg.co.src == $past(s_reg.co.src))
    else $error("irq sources changed between scans");
  AST_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!irq_out_n && s_reg.co.phase == PH_RUN && !rd_src && !rst_ev) |=> !irq_out_n)
    else $error("irq dropped without clear");
  AST_SW_RESET: assert property (@(posedge ref_clk) disable iff (!resetn)
    (sw_rst && s_reg.sy.rst_f) |=> s_reg.co.phase == PH_LOAD && s_reg.co.idx == 4'h0)
    else $error("software reset not taken");
  AST_HW_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!s_reg.sy.rst_f) [*2] |-> s_reg.co.phase == PH_HOLD && !irq_out_n)
    else $error("not held in reset while pin low");
  AST_PWM_WRAP: assert property (@(posedge ref_clk) disable iff (!resetn)
    (s_reg.co.pwm == 8'hFF && s_reg.co.pre == PWM_DIV - 6'h01 && !rst_ev)
    |=> s_reg.co.pwm == 8'h00 ##1 s_reg.co.pwm == 8'h00)
    else $error("pwm counter did not wrap");
  AST_BURN_DONE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (s_reg.co.phase == PH_BURN && s_reg.co.idx == SPM_LAST && !rst_ev)
    |=> s_reg.co.pend[IRQ_NVM] || s_reg.co.src[IRQ_NVM])
    else $error("burn done not flagged");
  CV_BOOT: cover property (@(posedge ref_clk) disable iff (!resetn)
    $rose(irq_out_n));
  CV_READ_CLEAR: cover property (@(posedge ref_clk) disable iff (!resetn) rd_src);
  CV_SW_RESET: cover property (@(posedge ref_clk) disable iff (!resetn) sw_rst);
  CV_GPI_WAKE: cover property (@(posedge ref_clk) disable iff (!resetn)
    s_reg.co.mode == OPM_DOZE ##1 s_reg.co.mode == OPM_ACTIVE);
endmodule // touch_host_control_irq

// ### design/touch_ctrl_pkg.sv
package touch_ctrl_pkg;
  localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h2B;
  localparam logic [7:0] REG_IRQ_SRC  = 8'h00;
  localparam logic [7:0] REG_BTN_STAT = 8'h01;
  localparam logic [7:0] REG_PIN_STAT = 8'h02;
  localparam logic [7:0] REG_OPM_STAT = 8'h03;
  localparam logic [7:0] REG_MODE_REQ = 8'h04;
  localparam logic [7:0] REG_SPM_ADDR = 8'h05;
  localparam logic [7:0] REG_SPM_DATA = 8'h06;
  localparam logic [7:0] REG_NVM_CTRL = 8'h07;
  localparam logic [7:0] REG_GPO_CTRL = 8'h08;
  localparam logic [7:0] REG_SPACE    = 8'h10;
  localparam logic [7:0] REG_SW_RESET = 8'hB1;
  localparam logic [7:0] SW_RESET_KEY1 = 8'hDE;
  localparam logic [7:0] SW_RESET_KEY2 = 8'h00;
  localparam logic [7:0] NVM_BURN_KEY  = 8'h5A;
  localparam logic [7:0] NVM_SIGNATURE = 8'hA5;
  localparam int NUM_PINS = 8;
  localparam logic [3:0] SPM_MODE_LO = 4'h0;
  localparam logic [3:0] SPM_MODE_HI = 4'h1;
  localparam logic [3:0] SPM_POL     = 4'h2;
  localparam logic [3:0] SPM_PULL_EN = 4'h3;
  localparam logic [3:0] SPM_PULL_UP = 4'h4;
  localparam logic [3:0] SPM_RISE    = 4'h5;
  localparam logic [3:0] SPM_FALL    = 4'h6;
  localparam logic [3:0] SPM_DEB     = 4'h7;
  localparam logic [3:0] SPM_BTN_IRQ = 4'h8;
  localparam logic [3:0] SPM_ADDR    = 4'h9;
  localparam logic [3:0] SPM_INTENS  = 4'hA;
  localparam logic [3:0] SPM_SIG     = 4'hF;
  localparam logic [3:0] SPM_LAST    = 4'hF;
  // Fixed defaults, index 15 first
  localparam logic [15:0][7:0] DEFAULT_SPM = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, {1'b0, I2C_ADDR_DEFAULT}, 8'h03, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'hAA, 8'hAA};
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int PWM_CLK_HZ = 2_000_000;
  localparam logic [5:0] PWM_DIV = 6'(REF_CLK_HZ / PWM_CLK_HZ);
  localparam int IRQ_OPMODE = 0;
  localparam int IRQ_COMP = 1;
  localparam int IRQ_TOUCH = 2;
  localparam int IRQ_RELEASE = 3;
  localparam int IRQ_GPI = 4;
  localparam int IRQ_SPM = 5;
  localparam int IRQ_NVM = 6;
  typedef enum logic [1:0] {PH_LOAD, PH_RUN, PH_HOLD, PH_BURN} phase_t;
  typedef enum logic [1:0] {OPM_SLEEP, OPM_DOZE, OPM_ACTIVE} opmode_t;
  typedef enum logic [1:0] {PIN_INPUT, PIN_HOST_PWM, PIN_OUTPUT} pin_mode_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK} i2c_st_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
  } pins_t;
  typedef struct packed {
    logic [2:0] scl, sda, rst;
    logic [7:0][2:0] gin;
    logic scl_f, sda_f, rst_f;
    logic [7:0] gin_f;
  } sync_t;
  typedef struct packed {
    phase_t phase;
    logic [3:0] idx;
    logic use_nvm;
    logic [15:0][7:0] shadow_param_memory;
    opmode_t mode, mode_req;
    logic mode_pend;
    logic [6:0] src, pend;
    logic key_armed;
    i2c_st_t ist;
    logic [3:0] cnt;
    logic [7:0] sh, ptr, spm_ptr, pin_output_mode, btn, gdb, gval;
    logic rw, first, drv;
    logic [5:0] pre;
    logic [7:0] pwm;
    pins_t pins;
  } core_t;
  typedef struct packed {
    sync_t sy;
    core_t co;
  } state_t;
  localparam core_t CORE_RESET = '{phase: PH_LOAD, mode: OPM_ACTIVE, mode_req: OPM_ACTIVE,
    ist: I_IDLE, pins: '{out: 8'h00, oe_n: 8'hFF, pull_up: 8'h00, pull_dn: 8'h00},
    default: '0};
  localparam sync_t SYNC_RESET = '{scl: 3'h7, sda: 3'h7, rst: 3'h7, gin: '0, scl_f: 1'b1,
    sda_f: 1'b1, rst_f: 1'b1, gin_f: 8'h00};
endpackage

// ### tb/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
  // Clock and bus
  input  wire logic ref_clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tq(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Clock stands high between frames
  task automatic start();
    if (scl === 1'b0) begin
      tq(2);
      sda_drv = 1'b1;
      tq(2);
      scl = 1'b1;
    end
    tq(4);
    sda_drv = 1'b0;
    tq(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tq(2);
    sda_drv = 1'b0;
    tq(2);
    scl = 1'b1;
    tq(4);
    sda_drv = 1'b1;
    tq(8);
  endtask
  // MSB first, ninth slot is the acknowledge
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    for (int i = 8; i >= 0; i--) begin
      // Data changes after the slave has let go of its acknowledge
      tq(4);
      sda_drv = (i > 0) ? tx[i-1] : last;
      tq(1);
      scl = 1'b1;
      tq(3);
      if (i > 0) rx[i-1] = sda_in;
      else ack = ~sda_in;
      scl = 1'b0;
    end
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d0,
                    input logic [7:0] d1, input logic two, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    xfer(d0, 1'b1, rx, a2);
    a3 = 1'b1;
    if (two) xfer(d1, 1'b1, rx, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    start();
    xfer({dev, 1'b1}, 1'b1, rx, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // i2c_host_model

// ### tb/touch_host_control_irq_tb_top.sv
`timescale 1ns/1ps
module touch_host_control_irq_tb_top;
  import touch_ctrl_pkg::*;
  logic       ref_clk, resetn, hw_reset_pin_n, scan_tick, comp_done, ok;
  logic       scl, sda_drv, sda_o, sda_oe_n, sda_in, irq_out_n;
  logic [7:0] button_touch, gpio_i, v;
  logic [6:0] dev;
  opmode_t    opmode;
  pins_t      gpio;
  int         n_errors, n_compared;
  assign sda_in = sda_drv & (sda_oe_n | sda_o);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  touch_host_control_irq u_touch_host_control_irq (
    .ref_clk(ref_clk), .resetn(resetn), .hw_reset_pin_n(hw_reset_pin_n),
    .scl_i(scl), .sda_i(sda_in), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .scan_tick(scan_tick), .comp_done(comp_done), .button_touch(button_touch),
    .opmode(opmode), .gpio_i(gpio_i), .gpio(gpio), .irq_out_n(irq_out_n));
  i2c_host_model u_i2c_host_model (
    .ref_clk(ref_clk), .sda_in(sda_in), .scl(scl), .sda_drv(sda_drv));
  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic tq(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
                    input logic two);
    u_i2c_host_model.wr(dev, ptr, d0, d1, two, ok);
    check(8'(ok), 8'h01, "write acked");
  endtask
  task automatic rd(input logic [7:0] ptr);
    u_i2c_host_model.rd(dev, ptr, v, ok);
  endtask
  task automatic tick();
    scan_tick = 1'b1;
    tq(1);
    scan_tick = 1'b0;
    tq(2);
  endtask
  task automatic wait_irq(input logic lvl, input int lim);
    for (int k = 0; k < lim && irq_out_n !== lvl; k++) tq(1);
  endtask
  task automatic t_power_up();
    resetn = 1'b0;
    tq(16);
    check(8'(irq_out_n), 8'h00, "irq in reset");
    resetn = 1'b1;
    tq(2);
    check(8'(irq_out_n), 8'h00, "irq in load");
    wait_irq(1'b1, 60);
    check(8'(irq_out_n), 8'h01, "irq released");
    check(gpio.oe_n, 8'h00, "pins driven");
    check(8'(opmode), 8'(OPM_ACTIVE), "mode after reset");
  endtask
  task automatic t_regs();
    rd(REG_OPM_STAT);
    check(v, 8'(OPM_ACTIVE), "mode register");
    rd(8'h20);
    check(v, 8'h00, "unmapped read");
    u_i2c_host_model.rd(7'h2C, REG_OPM_STAT, v, ok);
    check(8'(ok), 8'h00, "foreign address");
  endtask
  task automatic t_irq();
    tick();
    rd(REG_IRQ_SRC);
    comp_done = 1'b1;
    tq(1);
    comp_done = 1'b0;
    tq(4);
    check(8'(irq_out_n), 8'h01, "held until scan");
    tick();
    check(8'(irq_out_n), 8'h00, "compensation irq");
    button_touch = 8'h01;
    tq(2);
    tick();
    check(8'(irq_out_n), 8'h00, "still asserted");
    rd(REG_IRQ_SRC);
    check(v, 8'h06, "accumulated sources");
    check(8'(irq_out_n), 8'h01, "cleared by read");
    rd(REG_BTN_STAT);
    check(v, 8'h01, "button status");
    button_touch = 8'h00;
    tq(2);
    tick();
    rd(REG_IRQ_SRC);
    check(v, 8'h08, "release source");
  endtask
  task automatic t_pins();
    wr(REG_SPM_ADDR, {4'h0, SPM_POL}, 8'h01, 1'b1);
    tq(4);
    check(8'(gpio.out[0]), 8'h01, "inverted low output");
    wr(REG_GPO_CTRL, 8'h01, 8'h00, 1'b0);
    tq(4);
    check(8'(gpio.out[0]), 8'h00, "inverted high output");
    wr(REG_SPM_ADDR, {4'h0, SPM_MODE_LO}, 8'h00, 1'b1);
    tq(4);
    check(gpio.oe_n, 8'h0F, "pins 0-3 inputs");
    wr(REG_SPM_ADDR, {4'h0, SPM_PULL_EN}, 8'h03, 1'b1);
    wr(REG_SPM_ADDR, {4'h0, SPM_PULL_UP}, 8'h01, 1'b1);
    tq(4);
    check(gpio.pull_up, 8'h01, "pull-up on pin 0");
    check(gpio.pull_dn, 8'h02, "pull-down on pin 1");
    gpio_i = 8'h01;
    tq(10);
    tick();
    check(8'(irq_out_n), 8'h00, "pin edge irq");
    rd(REG_IRQ_SRC);
    check(v, 8'h30, "pin edge and shadow write");
    rd(REG_PIN_STAT);
    check(v, 8'h01, "input level");
  endtask
  task automatic t_mode();
    wr(REG_MODE_REQ, 8'(OPM_DOZE), 8'h00, 1'b0);
    check(8'(opmode), 8'(OPM_ACTIVE), "mode waits for scan");
    tick();
    check(8'(opmode), 8'(OPM_DOZE), "doze entered");
    tick();
    rd(REG_IRQ_SRC);
    check(v & 8'h01, 8'h01, "mode entry source");
    gpio_i = 8'h00;
    tq(10);
    tick();
    check(8'(opmode), 8'(OPM_ACTIVE), "woken by pin fall");
  endtask
  task automatic t_resets();
    wr(REG_SW_RESET, SW_RESET_KEY1, 8'h00, 1'b0);
    wr(REG_SW_RESET, 8'h11, 8'h00, 1'b0);
    tq(20);
    check(gpio.oe_n, 8'h0F, "wrong key ignored");
    wr(REG_SW_RESET, SW_RESET_KEY1, 8'h00, 1'b0);
    wr(REG_SW_RESET, SW_RESET_KEY2, 8'h00, 1'b0);
    wait_irq(1'b1, 60);
    check(8'(irq_out_n), 8'h01, "released after soft reset");
    check(gpio.oe_n, 8'h00, "shadow reloaded");
    wr(REG_SPM_ADDR, {4'h0, SPM_POL}, 8'h01, 1'b1);
    hw_reset_pin_n = 1'b0;
    tq(30);
    check(8'(irq_out_n), 8'h00, "irq in pin reset");
    hw_reset_pin_n = 1'b1;
    wait_irq(1'b1, 80);
    check(8'(irq_out_n), 8'h01, "released after pin");
    check(8'(gpio.out[0]), 8'h00, "host shadow lost");
  endtask
  task automatic t_burn();
    wr(REG_SPM_ADDR, {4'h0, SPM_ADDR}, 8'h33, 1'b1);
    dev = 7'h33;
    wr(REG_NVM_CTRL, NVM_BURN_KEY, 8'h00, 1'b0);
    tq(30);
    tick();
    rd(REG_IRQ_SRC);
    check(v, 8'h60, "burn done source");
    t_power_up();
    rd(REG_OPM_STAT);
    check(8'(ok), 8'h01, "stored address used");
    u_i2c_host_model.rd(I2C_ADDR_DEFAULT, REG_OPM_STAT, v, ok);
    check(8'(ok), 8'h00, "default address dropped");
  endtask
  initial begin
    n_errors = 0;
    n_compared = 0;
    resetn = 1'b0;
    hw_reset_pin_n = 1'b1;
    scan_tick = 1'b0;
    comp_done = 1'b0;
    button_touch = 8'h00;
    gpio_i = 8'h00;
    dev = I2C_ADDR_DEFAULT;
    t_power_up();
    t_regs();
    t_irq();
    t_pins();
    t_mode();
    t_resets();
    t_burn();
    summarize();
  end
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule // touch_host_control_irq_tb_top
